// >>> gpab_pin_if.sv
interface gpab_pin_if;
    import gpab_pkg::*;
    gpab_byte_t pin_raw;
    gpab_byte_t pin_sync;
    modport sync_side (input pin_raw, output pin_sync);
    modport user_side (output pin_raw, input pin_sync);
endinterface : gpab_pin_if

// >>> gpab_pin_model.sv
module gpab_pin_model (
    // Clock
    input wire logic clk,
    // Port A
    input wire gpab_pkg::gpab_byte_t pa_o,
    input wire gpab_pkg::gpab_byte_t pa_oe,
    input wire gpab_pkg::gpab_byte_t pa_pu,
    input wire gpab_pkg::gpab_byte_t ext_a,
    input wire gpab_pkg::gpab_byte_t ext_a_en,
    output gpab_pkg::gpab_byte_t pa_i,
    // Port B
    input wire gpab_pkg::gpab_byte_t pb_o,
    input wire gpab_pkg::gpab_byte_t pb_oe,
    input wire gpab_pkg::gpab_byte_t pb_pu,
    output gpab_pkg::gpab_byte_t pb_i
);
    timeunit 1ns;
    timeprecision 1ps;
    import gpab_pkg::*;
    // Undriven pins without a pullup wander so a stale level is never read back
    gpab_byte_t float_r = 8'h55;
    always @(posedge clk) begin
        float_r <= ~float_r;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pa_i[i] = pa_oe[i] ? pa_o[i] : ext_a_en[i] ? ext_a[i] : pa_pu[i] | float_r[i];
            pb_i[i] = pb_oe[i] ? pb_o[i] : pb_pu[i] | float_r[i];
        end
    end
endmodule : gpab_pin_model

// >>> gpab_pkg.sv
// Behaviour
// - Port A is eight bidirectional pins, each with a data latch that software reads and writes.
// - The port A data latch keeps its contents through reset.
// - A port A direction bit of 1 enables that pin's output buffer, 0 leaves the pin an input.
// - Reset clears all port A direction bits so every port A pin starts as an input.
// - Reading port A data returns the latch for output bits and the pin level for input bits.
// - Data latches accept writes whatever the direction, without changing what an input reads.
// - A set keyboard interrupt enable bit makes that port A pin an interrupt input with pullup.
// - Port B is eight bidirectional pins whose output drivers are open-drain, except on pins that the sharing module claims.
// - The port B data latch keeps its contents through reset; each pin follows its direction bit, except pins the sharing module claims, which follow PB_ALT_OE.
// - Each LED drive option bit enables direct LED drive on its port B pin.
// - Each pullup control bit enables the internal pullup on its port B pin.
// - A port B direction bit of 1 enables that pin's output buffer, 0 disables it.
// - Reset clears all port B direction bits so every port B pin starts as an input.
// - Reading port B data returns the latch for output bits and the pin level for input bits.
package gpab_pkg;
    typedef logic [7:0] gpab_byte_t;
    // Word indices; byte address is four times the index
    localparam logic [7:0] IDX_PORT_A_DATA = 8'h00;
    localparam logic [7:0] IDX_PORT_B_DATA = 8'h01;
    localparam logic [7:0] IDX_PORT_A_DIR = 8'h04;
    localparam logic [7:0] IDX_PORT_B_DIR = 8'h05;
    localparam logic [7:0] IDX_KBD_IRQ_EN = 8'h17;
    localparam logic [7:0] IDX_LED_DRIVE = 8'h1A;
    localparam logic [7:0] IDX_OPTION_TWO = 8'h1B;
    localparam logic [7:0] IDX_PULLUP_B = 8'h3E;
    localparam gpab_byte_t DIR_RESET = 8'h00;
    localparam gpab_byte_t OPT_RESET = 8'h00;
    localparam gpab_byte_t LATCH_INIT = 8'h00;
    localparam logic [5:0] OPT2_MASK = 6'h3F;
endpackage : gpab_pkg

// >>> gpab_properties.sv
module gpab_checker (
    // System
    input wire logic CLK_SYS,
    input wire logic RESET,
    // Bus
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [9:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // Pins
    input wire gpab_pkg::gpab_byte_t PA_OE,
    input wire gpab_pkg::gpab_byte_t PA_PULLUP,
    input wire gpab_pkg::gpab_byte_t PB_O,
    input wire gpab_pkg::gpab_byte_t PB_OE,
    input wire gpab_pkg::gpab_byte_t PB_PULLUP,
    input wire gpab_pkg::gpab_byte_t PB_ALT_CLAIM
);
    timeunit 1ns;
    timeprecision 1ps;
    import gpab_pkg::*;
    logic req;
    logic wr;
    assign req = WB_CYC_I & WB_STB_I;
    assign wr = req & WB_WE_I & WB_SEL_I[0] & WB_ACK_O;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    AST_ACK_ONE: assert property (req && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack missing after request");
    AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    AST_RST_DIR: assert property ($fell(RESET) |-> PA_OE == 8'h00 && PB_OE == 8'h00)
        else $error("pins not inputs after reset");
    AST_KBD_INPUT: assert property ((PA_OE & PA_PULLUP) == 8'h00)
        else $error("keyboard pin driven");
    AST_PB_OD: assert property ((PB_ALT_CLAIM == 8'h00) [*4] |-> PB_O == 8'h00)
        else $error("port b drives high");
    AST_UNMAPPED: assert property (req && !WB_ACK_O && !WB_WE_I && WB_ADR_I[9:2] == 8'h02
        |=> WB_DAT_O == 32'h0) else $error("unmapped read not zero");
    AST_PULL: assert property (wr && WB_ADR_I[9:2] == IDX_PULLUP_B
        |=> PB_PULLUP == $past(WB_DAT_I[7:0])) else $error("pullup not updated");
    AST_A_DIR: assert property (wr && WB_ADR_I[9:2] == IDX_PORT_A_DIR
        |=> PA_OE == ($past(WB_DAT_I[7:0]) & ~PA_PULLUP)) else $error("port a oe wrong");
endmodule : gpab_checker

bind gpab_top gpab_checker chk_u (.CLK_SYS(CLK_SYS), .RESET(RESET), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .PA_OE(PA_OE),
    .PA_PULLUP(PA_PULLUP), .PB_O(PB_O), .PB_OE(PB_OE), .PB_PULLUP(PB_PULLUP),
    .PB_ALT_CLAIM(PB_ALT_CLAIM));

// >>> gpab_sync.sv
module gpab_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins
    gpab_pin_if.sync_side pins
);
    import gpab_pkg::*;
    gpab_byte_t meta_r;
    gpab_byte_t meta_nxt;
    gpab_byte_t stable_r;
    gpab_byte_t stable_nxt;

    always_comb begin
        meta_nxt = pins.pin_raw;
        stable_nxt = meta_r;
    end

    // First stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= 8'h00;
            stable_r <= 8'h00;
        end else begin
            meta_r <= meta_nxt;
            stable_r <= stable_nxt;
        end
    end

    assign pins.pin_sync = stable_r;
endmodule : gpab_sync

// >>> gpab_tb_top.sv
module gpab_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import gpab_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic ack;
    logic [9:0] adr = 10'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] rdata;
    logic [5:0] opt2;
    gpab_byte_t pa_o, pa_oe, pa_pu, kbd, pb_o, pb_oe, pb_pu, led, pa_i, pb_i;
    gpab_byte_t ext_a = 8'h00, ext_a_en = 8'h00, claim = 8'h00, alt_out = 8'h00, alt_oe = 8'h00;
    int failures = 0;
    int cmp_count = 0;
    always #5 clk = ~clk;
    gpab_top dut_u (.CLK_SYS(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .PA_I(pa_i), .PA_O(pa_o), .PA_OE(pa_oe), .PA_PULLUP(pa_pu), .KBD_IRQ_PIN(kbd),
        .PB_I(pb_i), .PB_O(pb_o), .PB_OE(pb_oe), .PB_PULLUP(pb_pu), .PB_LED_DRIVE(led),
        .PB_ALT_CLAIM(claim), .PB_ALT_OUT(alt_out), .PB_ALT_OE(alt_oe), .OPTION_TWO(opt2));
    gpab_pin_model pins_u (.clk(clk), .pa_o(pa_o), .pa_oe(pa_oe), .pa_pu(pa_pu), .ext_a(ext_a),
        .ext_a_en(ext_a_en), .pa_i(pa_i), .pb_o(pb_o), .pb_oe(pb_oe), .pb_pu(pb_pu), .pb_i(pb_i));
    function automatic logic [9:0] ba(input logic [7:0] i);
        return {i, 2'b00};
    endfunction : ba
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task wb(input logic w, input logic [9:0] a, input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat_i <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1);
        rdata = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        // Ack comes one cycle after the taking edge
        check("ack delay", n, 32'h2);
    endtask : wb
    task wr(input logic [9:0] a, input logic [7:0] d);
        wb(1'b1, a, 4'h1, {24'h0, d});
    endtask : wr
    task rd(input logic [9:0] a, input logic [7:0] exp, input string what);
        wb(1'b0, a, 4'hF, 32'h0);
        check(what, rdata, {24'h0, exp});
    endtask : rd
    task settle;
        repeat (4) @(posedge clk);
    endtask : settle
    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #20000;
        failures++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(ba(IDX_PORT_A_DIR), DIR_RESET, "a dir");
        rd(ba(IDX_PORT_B_DIR), DIR_RESET, "b dir");
        rd(ba(IDX_PULLUP_B), OPT_RESET, "pullup");
        check("a oe", pa_oe, 8'h00);
        $display("test reset done");
        ext_a <= 8'hA5;
        ext_a_en <= 8'hFF;
        // Latch loaded before any direction bit turns on
        wr(ba(IDX_PORT_A_DATA), 8'h3C);
        settle();
        rd(ba(IDX_PORT_A_DATA), 8'hA5, "a pins");
        wr(ba(IDX_PORT_A_DIR), 8'h0F);
        settle();
        rd(ba(IDX_PORT_A_DATA), 8'hAC, "a mixed");
        check("a oe", pa_oe, 8'h0F);
        check("a out", pa_o[3:0], 4'hC);
        ext_a_en <= 8'h00;
        wr(ba(IDX_PORT_A_DIR), 8'hFF);
        wr(ba(IDX_KBD_IRQ_EN), 8'h81);
        settle();
        check("a oe kbd", pa_oe, 8'h7E);
        check("a pullup", pa_pu, 8'h81);
        check("kbd pins", kbd, 8'h81);
        rd(ba(IDX_KBD_IRQ_EN), 8'h81, "kbd en rd");
        // Direction bits still choose latch or pin on a read
        rd(ba(IDX_PORT_A_DATA), 8'h3C, "a kbd");
        wr(ba(IDX_KBD_IRQ_EN), 8'h00);
        $display("test port a done");
        wr(ba(IDX_PULLUP_B), 8'hFF);
        wr(ba(IDX_PORT_B_DATA), 8'h96);
        wr(ba(IDX_PORT_B_DIR), 8'hFF);
        settle();
        check("b oe", pb_oe, 8'h69);
        check("b out", pb_o, 8'h00);
        check("b pullup", pb_pu, 8'hFF);
        rd(ba(IDX_PORT_B_DATA), 8'h96, "b latch");
        wr(ba(IDX_PORT_B_DIR), 8'h0F);
        settle();
        check("b oe half", pb_oe, 8'h09);
        rd(ba(IDX_PORT_B_DATA), 8'hF6, "b mixed");
        $display("test port b done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(ba(IDX_PORT_B_DIR), DIR_RESET, "b dir rst");
        wr(ba(IDX_PORT_B_DIR), 8'hFF);
        wr(ba(IDX_PORT_A_DIR), 8'hFF);
        settle();
        rd(ba(IDX_PORT_B_DATA), 8'h96, "b kept");
        rd(ba(IDX_PORT_A_DATA), 8'h3C, "a kept");
        $display("test retention done");
        wr(ba(IDX_LED_DRIVE), 8'h5A);
        wb(1'b1, ba(IDX_LED_DRIVE), 4'hE, 32'h0000_00FF);
        wr(ba(IDX_OPTION_TWO), 8'hFF);
        settle();
        check("led", led, 8'h5A);
        rd(ba(IDX_LED_DRIVE), 8'h5A, "led rd");
        check("opt two", opt2, 6'h3F);
        rd(ba(IDX_OPTION_TWO), 8'h3F, "opt two rd");
        rd(10'h008, 8'h00, "unmapped");
        claim <= 8'h01;
        alt_out <= 8'h01;
        settle();
        check("claim oe", pb_oe[0], 1'b0);
        check("claim out", pb_o[0], 1'b1);
        $display("test options done");
        give_verdict();
    end
endmodule : gpab_tb_top

// >>> gpab_top.sv
module gpab_top (
    // System
    input wire logic CLK_SYS,
    input wire logic RESET,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [9:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Port A pins
    input wire gpab_pkg::gpab_byte_t PA_I,
    output gpab_pkg::gpab_byte_t PA_O,
    output gpab_pkg::gpab_byte_t PA_OE,
    output gpab_pkg::gpab_byte_t PA_PULLUP,
    output gpab_pkg::gpab_byte_t KBD_IRQ_PIN,
    // Port B pins
    input wire gpab_pkg::gpab_byte_t PB_I,
    output gpab_pkg::gpab_byte_t PB_O,
    output gpab_pkg::gpab_byte_t PB_OE,
    output gpab_pkg::gpab_byte_t PB_PULLUP,
    output gpab_pkg::gpab_byte_t PB_LED_DRIVE,
    // Port B sharing module claim
    input wire gpab_pkg::gpab_byte_t PB_ALT_CLAIM,
    input wire gpab_pkg::gpab_byte_t PB_ALT_OUT,
    input wire gpab_pkg::gpab_byte_t PB_ALT_OE,
    // Option register two contents
    output logic [5:0] OPTION_TWO
);
    import gpab_pkg::*;

    gpab_pin_if pa_if ();
    gpab_pin_if pb_if ();
    gpab_pin_if claim_if ();
    gpab_pin_if alt_out_if ();
    gpab_pin_if alt_oe_if ();

    assign pa_if.pin_raw = PA_I;
    assign pb_if.pin_raw = PB_I;
    assign claim_if.pin_raw = PB_ALT_CLAIM;
    assign alt_out_if.pin_raw = PB_ALT_OUT;
    assign alt_oe_if.pin_raw = PB_ALT_OE;

    // Pins and the sharing module come from outside this clock
    gpab_sync u_sync_a (.clk(CLK_SYS), .rst(RESET), .pins(pa_if.sync_side));
    gpab_sync u_sync_b (.clk(CLK_SYS), .rst(RESET), .pins(pb_if.sync_side));
    gpab_sync u_sync_c (.clk(CLK_SYS), .rst(RESET), .pins(claim_if.sync_side));
    gpab_sync u_sync_o (.clk(CLK_SYS), .rst(RESET), .pins(alt_out_if.sync_side));
    gpab_sync u_sync_e (.clk(CLK_SYS), .rst(RESET), .pins(alt_oe_if.sync_side));

    gpab_byte_t pa_pin;
    gpab_byte_t pb_pin;
    gpab_byte_t claim;
    assign pa_pin = pa_if.pin_sync;
    assign pb_pin = pb_if.pin_sync;
    assign claim = claim_if.pin_sync;

    // Registers
    gpab_byte_t port_a_data_latch_r, port_a_data_latch_nxt;
    gpab_byte_t port_b_data_latch_r, port_b_data_latch_nxt;
    gpab_byte_t port_a_direction_r, port_a_direction_nxt;
    gpab_byte_t port_b_direction_r, port_b_direction_nxt;
    gpab_byte_t keyboard_irq_enable_reg_r, keyboard_irq_enable_reg_nxt;
    gpab_byte_t led_drive_option_r, led_drive_option_nxt;
    logic [5:0] port_option_two_r, port_option_two_nxt;
    gpab_byte_t port_b_pullup_control_r, port_b_pullup_control_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    logic req;
    logic wr_en;
    logic [7:0] idx;
    assign req = WB_CYC_I && WB_STB_I && !ack_r;
    assign wr_en = req && WB_WE_I && WB_SEL_I[0];
    assign idx = WB_ADR_I[9:2];

    // Register file and bus answer
    always_comb begin
        port_a_data_latch_nxt = port_a_data_latch_r;
        port_b_data_latch_nxt = port_b_data_latch_r;
        port_a_direction_nxt = port_a_direction_r;
        port_b_direction_nxt = port_b_direction_r;
        keyboard_irq_enable_reg_nxt = keyboard_irq_enable_reg_r;
        led_drive_option_nxt = led_drive_option_r;
        port_option_two_nxt = port_option_two_r;
        port_b_pullup_control_nxt = port_b_pullup_control_r;
        ack_nxt = req;
        rdata_nxt = 32'h0000_0000;
        if (wr_en) begin
            case (idx)
                IDX_PORT_A_DATA: port_a_data_latch_nxt = WB_DAT_I[7:0];
                IDX_PORT_B_DATA: port_b_data_latch_nxt = WB_DAT_I[7:0];
                IDX_PORT_A_DIR: port_a_direction_nxt = WB_DAT_I[7:0];
                IDX_PORT_B_DIR: port_b_direction_nxt = WB_DAT_I[7:0];
                IDX_KBD_IRQ_EN: keyboard_irq_enable_reg_nxt = WB_DAT_I[7:0];
                IDX_LED_DRIVE: led_drive_option_nxt = WB_DAT_I[7:0];
                IDX_OPTION_TWO: port_option_two_nxt = WB_DAT_I[5:0] & OPT2_MASK;
                IDX_PULLUP_B: port_b_pullup_control_nxt = WB_DAT_I[7:0];
                default: begin
                end
            endcase
        end
        if (req && !WB_WE_I) begin
            case (idx)
                // Latch for outputs, pin level for inputs
                IDX_PORT_A_DATA: rdata_nxt[7:0] = (port_a_direction_r & port_a_data_latch_r)
                    | (~port_a_direction_r & pa_pin);
                IDX_PORT_B_DATA: rdata_nxt[7:0] = (port_b_direction_r & port_b_data_latch_r)
                    | (~port_b_direction_r & pb_pin);
                IDX_PORT_A_DIR: rdata_nxt[7:0] = port_a_direction_r;
                IDX_PORT_B_DIR: rdata_nxt[7:0] = port_b_direction_r;
                IDX_KBD_IRQ_EN: rdata_nxt[7:0] = keyboard_irq_enable_reg_r;
                IDX_LED_DRIVE: rdata_nxt[7:0] = led_drive_option_r;
                IDX_OPTION_TWO: rdata_nxt[5:0] = port_option_two_r;
                IDX_PULLUP_B: rdata_nxt[7:0] = port_b_pullup_control_r;
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Data latches carry no reset so they survive it
    always_ff @(posedge CLK_SYS) begin
        port_a_data_latch_r <= port_a_data_latch_nxt;
        port_b_data_latch_r <= port_b_data_latch_nxt;
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            port_a_direction_r <= DIR_RESET;
            port_b_direction_r <= DIR_RESET;
            keyboard_irq_enable_reg_r <= OPT_RESET;
            led_drive_option_r <= OPT_RESET;
            port_option_two_r <= 6'h00;
            port_b_pullup_control_r <= OPT_RESET;
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            port_a_direction_r <= port_a_direction_nxt;
            port_b_direction_r <= port_b_direction_nxt;
            keyboard_irq_enable_reg_r <= keyboard_irq_enable_reg_nxt;
            led_drive_option_r <= led_drive_option_nxt;
            port_option_two_r <= port_option_two_nxt;
            port_b_pullup_control_r <= port_b_pullup_control_nxt;
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Pin drivers
    gpab_byte_t pa_o_nxt, pa_oe_nxt, pa_pu_nxt, kbd_nxt;
    gpab_byte_t pb_o_nxt, pb_oe_nxt, pb_pu_nxt, pb_led_nxt;
    gpab_byte_t pa_o_r, pa_oe_r, pa_pu_r, kbd_r;
    gpab_byte_t pb_o_r, pb_oe_r, pb_pu_r, pb_led_r;

    for (genvar i = 0; i < 8; i++) begin : g_pin
        always_comb begin
            // Keyboard claim turns the pin into a pulled-up input
            if (keyboard_irq_enable_reg_r[i]) begin
                pa_oe_nxt[i] = 1'b0;
                pa_pu_nxt[i] = 1'b1;
            end else begin
                pa_oe_nxt[i] = port_a_direction_r[i];
                pa_pu_nxt[i] = 1'b0;
            end
            pa_o_nxt[i] = port_a_data_latch_r[i];
            kbd_nxt[i] = keyboard_irq_enable_reg_r[i] & pa_pin[i];
            if (claim[i]) begin
                pb_o_nxt[i] = alt_out_if.pin_sync[i];
                pb_oe_nxt[i] = alt_oe_if.pin_sync[i];
            end else begin
                // Open drain: drive only low, release for a one
                pb_o_nxt[i] = 1'b0;
                pb_oe_nxt[i] = port_b_direction_r[i] & ~port_b_data_latch_r[i];
            end
            pb_pu_nxt[i] = port_b_pullup_control_r[i];
            pb_led_nxt[i] = led_drive_option_r[i];
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            pa_o_r <= LATCH_INIT;
            pa_oe_r <= DIR_RESET;
            pa_pu_r <= OPT_RESET;
            kbd_r <= OPT_RESET;
            pb_o_r <= LATCH_INIT;
            pb_oe_r <= DIR_RESET;
            pb_pu_r <= OPT_RESET;
            pb_led_r <= OPT_RESET;
        end else begin
            pa_o_r <= pa_o_nxt;
            pa_oe_r <= pa_oe_nxt;
            pa_pu_r <= pa_pu_nxt;
            kbd_r <= kbd_nxt;
            pb_o_r <= pb_o_nxt;
            pb_oe_r <= pb_oe_nxt;
            pb_pu_r <= pb_pu_nxt;
            pb_led_r <= pb_led_nxt;
        end
    end

    assign WB_DAT_O = rdata_r;
    assign WB_ACK_O = ack_r;
    assign PA_O = pa_o_r;
    assign PA_OE = pa_oe_r;
    assign PA_PULLUP = pa_pu_r;
    assign KBD_IRQ_PIN = kbd_r;
    assign PB_O = pb_o_r;
    assign PB_OE = pb_oe_r;
    assign PB_PULLUP = pb_pu_r;
    assign PB_LED_DRIVE = pb_led_r;
    assign OPTION_TWO = port_option_two_r;
endmodule : gpab_top
